// [inc/synth_cfg_regs.svh]
/*
  Register constants for the synthesizer configuration words three to five.
  Assumes 32-bit serial words with the 3-bit select code in bits [2:0].
*/
`ifndef SYNTH_CFG_REGS_SVH
`define SYNTH_CFG_REGS_SVH

// -----------------------------------------------------------------------
// Select codes
// -----------------------------------------------------------------------
`define SEL_LOCK_CFG 3'h2
`define SEL_FRAC_LOW 3'h3
`define SEL_DIV_PATH 3'h4
`define SEL_MOD_LOW 3'h5

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define SEL_LSB 0
`define LOW20_LSB 3
`define CLKDIV_LSB 3
`define BSDIV_LSB 15
`define VCOOFF_BIT 23
`define MUTE_BIT 24
`define EXTEN_BIT 25
`define DIVSEL_BIT 26
`define ROUTE_BIT 27
`define RFOE_BIT 28
`define PWR_LSB 29
`define LDMODE_LSB 23
`define LDCNT_BIT 3
`define LDPREC_BIT 4

// -----------------------------------------------------------------------
// Reset values and timing counts
// -----------------------------------------------------------------------
`define FRAC_LOW_RST 20'h00000
`define FRAC_HIGH_RST 12'h000
`define MOD_LOW_RST 20'h00002
`define MOD_HIGH_RST 12'h000
`define CLKDIV_RST 12'h001
`define BSDIV_RST 8'h01
`define PWR_RST 2'h2
`define LDMODE_RST 2'h1
`define LOCK_CNT_SLOW 6'h28
`define LOCK_CNT_FAST 6'h05
`define SCLK_HALF 4'h4
`define WORD_BITS 6'h20

`endif

// [inc/synth_cfg_pkg.sv]
/*
  Types for the configuration link; only the device end uses them.
  Assumes the constant header is included by each user.
*/
package synth_cfg_pkg;
  typedef logic [31:0] word_type;
  typedef enum logic [1:0] {
    PIN_LOW0 = 2'b00,
    PIN_LOCK = 2'b01,
    PIN_LOW2 = 2'b10,
    PIN_HIGH = 2'b11
  } lock_pin_mode_type;
endpackage

// [inc/synth_cfg_if.sv]
/*
  Three-wire serial programming link between host and synthesizer.
  Assumes both ends run on the same ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface synth_cfg_if;
  logic serClk;
  logic serData;
  logic serLoad;
  modport host (output serClk, output serData, output serLoad);
  modport device (input serClk, input serData, input serLoad);
endinterface
`default_nettype wire

// [src/synth_cfg_device.sv]
/*
  Synthesizer configuration registers three to five, with the lock settings
  of word two, loaded from a serial shift register.
  Assumes the link pins are asynchronous to ref_clk and that the lock
  comparison pulses come from the phase detector on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "synth_cfg_regs.svh"
module synth_cfg_device (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Serial link
  synth_cfg_if.device link,
  // Fraction and modulus high parts from words zero and one
  input wire logic [11:0] fracHigh,
  input wire logic [11:0] modHigh,
  // Analog side events
  input wire logic refPulse,
  input wire logic pfdPulse,
  input wire logic pfdInWindow,
  // Decoded outputs
  output logic [31:0] fracValue,
  output logic [31:0] modValue,
  output logic [11:0] clockDividerValue,
  output logic [7:0] bandSelectDivider,
  output logic bandClkPulse,
  output logic vcoPowerOff,
  output logic rfMuted,
  output logic extInputEnable,
  output logic divFromExternal,
  output logic extInputRoute,
  output logic rfOutputEnable,
  output logic [1:0] outputPowerLevel,
  output logic lockPin,
  output logic digitalLock
);

  // -----------------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------------
  // Three stages; a change counts only when stages two and three agree.
  logic [2:0] clkSync_q, datSync_q, ldSync_q;
  logic clkStable_q, ldStable_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clkSync_q <= 3'h0;
      datSync_q <= 3'h0;
      ldSync_q <= 3'h0;
    end else begin
      clkSync_q <= {clkSync_q[1:0], link.serClk};
      datSync_q <= {datSync_q[1:0], link.serData};
      ldSync_q <= {ldSync_q[1:0], link.serLoad};
    end
  end

  // Filtered levels track only agreed values.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clkStable_q <= 1'b0;
      ldStable_q <= 1'b0;
    end else begin
      if (clkSync_q[1] == clkSync_q[2]) clkStable_q <= clkSync_q[2];
      if (ldSync_q[1] == ldSync_q[2]) ldStable_q <= ldSync_q[2];
    end
  end

  wire clkRise = (clkSync_q[1] == clkSync_q[2]) && clkSync_q[2] && !clkStable_q;
  wire ldRise = (ldSync_q[1] == ldSync_q[2]) && ldSync_q[2] && !ldStable_q;

  // -----------------------------------------------------------------------
  // Shift register
  // -----------------------------------------------------------------------
  // MSB first; a bit count guards against short words.
  logic [31:0] shift_q;
  logic [5:0] bitCnt_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= 32'h0;
      bitCnt_q <= 6'h0;
    end else if (ldRise) begin
      bitCnt_q <= 6'h0;
    end else if (clkRise) begin
      shift_q <= {shift_q[30:0], datSync_q[2]};
      if (bitCnt_q != `WORD_BITS) bitCnt_q <= bitCnt_q + 6'h1;
    end
  end

  // Decode of the select code on a complete word.
  wire wordDone = ldRise && (bitCnt_q == `WORD_BITS);
  wire [2:0] selCode = shift_q[`SEL_LSB +: 3];
  wire wrLock = wordDone && (selCode == `SEL_LOCK_CFG);
  wire wrFrac = wordDone && (selCode == `SEL_FRAC_LOW);
  wire wrDiv = wordDone && (selCode == `SEL_DIV_PATH);
  wire wrMod = wordDone && (selCode == `SEL_MOD_LOW);

  // -----------------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------------
  logic [19:0] fracLow_q, modLow_q;
  logic [11:0] clkDiv_q;
  logic [7:0] bsDiv_q;
  logic vcoOff_q, mute_q, extEn_q, divSel_q, route_q, rfOe_q;
  logic [1:0] pwr_q, ldMode_q;
  logic ldCntSel_q;
  // Each word loads only its own fields, so words may arrive in any order.
  // The precision bit of word two only narrows the window that drives pfdInWindow, so it is not stored here.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fracLow_q <= `FRAC_LOW_RST;
      modLow_q <= `MOD_LOW_RST;
      clkDiv_q <= `CLKDIV_RST;
      bsDiv_q <= `BSDIV_RST;
      {vcoOff_q, mute_q, extEn_q, divSel_q, route_q, rfOe_q} <= 6'h0;
      pwr_q <= `PWR_RST;
      ldMode_q <= `LDMODE_RST;
      ldCntSel_q <= 1'b0;
    end else begin
      if (wrFrac) fracLow_q <= shift_q[`LOW20_LSB +: 20];
      if (wrMod) begin
        modLow_q <= shift_q[`LOW20_LSB +: 20];
        ldMode_q <= shift_q[`LDMODE_LSB +: 2];
      end
      if (wrDiv) begin
        clkDiv_q <= shift_q[`CLKDIV_LSB +: 12];
        bsDiv_q <= shift_q[`BSDIV_LSB +: 8];
        vcoOff_q <= shift_q[`VCOOFF_BIT];
        mute_q <= shift_q[`MUTE_BIT];
        extEn_q <= shift_q[`EXTEN_BIT];
        divSel_q <= shift_q[`DIVSEL_BIT];
        route_q <= shift_q[`ROUTE_BIT];
        rfOe_q <= shift_q[`RFOE_BIT];
        pwr_q <= shift_q[`PWR_LSB +: 2];
      end
      if (wrLock) begin
        ldCntSel_q <= shift_q[`LDCNT_BIT];
      end
    end
  end

  // -----------------------------------------------------------------------
  // Band-select clock divider
  // -----------------------------------------------------------------------
  // A zero divider wraps every 256 reference pulses; the host must never write it.
  logic [7:0] bsCnt_q;
  wire bsWrap = refPulse && (bsCnt_q >= bsDiv_q - 8'h1);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) bsCnt_q <= 8'h0;
    else if (bsWrap) bsCnt_q <= 8'h0;
    else if (refPulse) bsCnt_q <= bsCnt_q + 8'h1;
  end

  // -----------------------------------------------------------------------
  // Digital lock detect
  // -----------------------------------------------------------------------
  // The window width itself is analog; only the run length is counted here.
  logic [5:0] runCnt_q;
  wire [5:0] runNeed = ldCntSel_q ? `LOCK_CNT_FAST : `LOCK_CNT_SLOW;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) runCnt_q <= 6'h0;
    else if (pfdPulse && !pfdInWindow) runCnt_q <= 6'h0;
    else if (pfdPulse && runCnt_q < runNeed) runCnt_q <= runCnt_q + 6'h1;
  end
  wire lockNow = (runCnt_q >= runNeed);

  // Lock pin selection from the mode field.
  wire pinNext = (ldMode_q == synth_cfg_pkg::PIN_HIGH) ? 1'b1 :
                 (ldMode_q == synth_cfg_pkg::PIN_LOCK) ? lockNow : 1'b0;

  // -----------------------------------------------------------------------
  // Registered outputs
  // -----------------------------------------------------------------------
  // Every output leaves a flop, so the analog side never sees decode glitches.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fracValue <= {`FRAC_HIGH_RST, `FRAC_LOW_RST};
      modValue <= {`MOD_HIGH_RST, `MOD_LOW_RST};
      clockDividerValue <= `CLKDIV_RST;
      bandSelectDivider <= `BSDIV_RST;
      bandClkPulse <= 1'b0;
      vcoPowerOff <= 1'b0;
      rfMuted <= 1'b0;
      extInputEnable <= 1'b0;
      divFromExternal <= 1'b0;
      extInputRoute <= 1'b0;
      rfOutputEnable <= 1'b0;
      outputPowerLevel <= `PWR_RST;
      lockPin <= 1'b0;
      digitalLock <= 1'b0;
    end else begin
      fracValue <= {fracHigh, fracLow_q};
      modValue <= {modHigh, modLow_q};
      clockDividerValue <= clkDiv_q;
      bandSelectDivider <= bsDiv_q;
      bandClkPulse <= bsWrap;
      vcoPowerOff <= vcoOff_q;
      rfMuted <= mute_q && !lockNow;
      extInputEnable <= extEn_q;
      divFromExternal <= divSel_q && route_q;
      extInputRoute <= route_q;
      rfOutputEnable <= rfOe_q;
      outputPowerLevel <= pwr_q;
      lockPin <= pinNext;
      digitalLock <= lockNow;
    end
  end

endmodule
`default_nettype wire

// [src/synth_cfg_host.sv]
/*
  Host end: shifts one 32-bit word out over the serial link on request.
  Assumes the caller supplies a legal select code and field values.
*/
`timescale 1ns/10ps
`default_nettype none
`include "synth_cfg_regs.svh"
module synth_cfg_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // User request
  input wire logic sendValid,
  input wire logic [31:0] sendWord,
  output logic sendBusy,
  // Serial link
  synth_cfg_if.host link
);

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    LOW = 2'b01,
    HIGH = 2'b10,
    LOAD = 2'b11
  } host_state_type;

  host_state_type state_q;
  logic [31:0] word_q;
  logic [5:0] bitCnt_q;
  logic [3:0] tick_q;
  logic clk_q, dat_q, ld_q;

  wire tickDone = (tick_q == `SCLK_HALF);

  // Slow half-periods keep each level well past the three-stage filter.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= IDLE;
      word_q <= 32'h0;
      bitCnt_q <= 6'h0;
      tick_q <= 4'h0;
      clk_q <= 1'b0;
      dat_q <= 1'b0;
      ld_q <= 1'b0;
      sendBusy <= 1'b0;
    end else begin
      tick_q <= tickDone ? 4'h0 : tick_q + 4'h1;
      unique case (state_q)
        IDLE: begin
          ld_q <= 1'b0;
          if (sendValid) begin
            word_q <= sendWord;
            bitCnt_q <= 6'h0;
            tick_q <= 4'h0;
            sendBusy <= 1'b1;
            state_q <= LOW;
          end
        end
        LOW: if (tickDone) begin
          if (bitCnt_q == `WORD_BITS) begin
            ld_q <= 1'b1;
            state_q <= LOAD;
          end else begin
            dat_q <= word_q[31];
            word_q <= {word_q[30:0], 1'b0};
            state_q <= HIGH;
          end
        end
        HIGH: if (tickDone) begin
          clk_q <= ~clk_q;
          if (clk_q) begin
            bitCnt_q <= bitCnt_q + 6'h1;
            state_q <= LOW;
          end
        end
        LOAD: if (tickDone) begin
          ld_q <= 1'b0;
          sendBusy <= 1'b0;
          state_q <= IDLE;
        end
      endcase
    end
  end

  assign link.serClk = clk_q;
  assign link.serData = dat_q;
  assign link.serLoad = ld_q;

endmodule
`default_nettype wire

// [verification/synth_cfg_sva.sv]
/*
  Checker for the serial configuration link and the decoded device outputs.
  Assumes the bench instantiates it beside the link interface on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module synth_cfg_sva (
  // Clock, reset and link
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic serClk,
  input wire logic serData,
  input wire logic serLoad,
  // Device side
  input wire logic [11:0] fracHigh,
  input wire logic [11:0] modHigh,
  input wire logic [31:0] fracValue,
  input wire logic [31:0] modValue,
  input wire logic [11:0] clockDividerValue,
  input wire logic rfMuted,
  input wire logic digitalLock,
  input wire logic divFromExternal,
  input wire logic extInputRoute
);
  // ------------------------------------------------------------
  // Helper logic and properties
  // ------------------------------------------------------------
  logic [3:0] sinceLoad_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence loadPulse;
    serLoad[*5];
  endsequence
  // Cycles since the load strobe; registers may only move just after one.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) sinceLoad_q <= 4'hf;
    else if (serLoad) sinceLoad_q <= 4'h0;
    else if (sinceLoad_q != 4'hf) sinceLoad_q <= sinceLoad_q + 4'h1;
  end
  load_width_a: assert property ($rose(serLoad) |-> loadPulse) else $error("load strobe too short");
  load_idle_a: assert property (serLoad |-> !serClk) else $error("clock high during load");
  data_hold_a: assert property (serClk |-> $stable(serData)) else $error("data moved in clock high");
  frac_join_a: assert property ($past(reset_n) |-> fracValue[31:20] == $past(fracHigh))
    else $error("fraction upper part wrong");
  mod_join_a: assert property ($past(reset_n) |-> modValue[31:20] == $past(modHigh))
    else $error("modulus upper part wrong");
  ctrl_update_a: assert property ($changed(clockDividerValue) || $changed(fracValue[19:0]) |-> sinceLoad_q < 4'h9)
    else $error("register moved without load");
  mute_lock_a: assert property (digitalLock[*2] |-> !rfMuted) else $error("muted while locked");
  route_gate_a: assert property (divFromExternal |-> extInputRoute) else $error("unrouted input selected");
endmodule
`default_nettype wire

// [verification/synth_config_regs_three_to_five_test.sv]
/*
  Self-checking bench: host end drives the device end over the link.
  Assumes the design files and the link interface are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module synth_config_regs_three_to_five_test;
  // ------------------------------------------------------------
  // Stimulus, observation and bookkeeping
  // ------------------------------------------------------------
  logic ref_clk = 1'b0, reset_n = 1'b0, sendValid = 1'b0, sendBusy;
  logic [31:0] sendWord = 32'h0, w, expFrac, expMod, fracValue, modValue;
  logic [27:0] expCtrl;
  logic [11:0] fracHigh = 12'h0, modHigh = 12'h0, clockDividerValue;
  logic [7:0] bandSelectDivider, pc = 8'h0;
  logic refPulse = 1'b0, pfdPulse = 1'b0, pfdInWindow = 1'b0, bandClkPulse, vcoPowerOff, rfMuted;
  logic extInputEnable, divFromExternal, extInputRoute, rfOutputEnable, lockPin, digitalLock;
  logic [1:0] outputPowerLevel;
  logic [2:0] bad [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
  int err_total = 0, cmp_count = 0, bandCount = 0;
  wire [27:0] ctrlSeen = {clockDividerValue, bandSelectDivider, vcoPowerOff, rfMuted, extInputEnable,
    divFromExternal, extInputRoute, rfOutputEnable, outputPowerLevel};
  synth_cfg_if link();
  synth_cfg_host synth_cfg_host_i (.ref_clk(ref_clk), .reset_n(reset_n), .sendValid(sendValid),
    .sendWord(sendWord), .sendBusy(sendBusy), .link(link));
  synth_cfg_device synth_cfg_device_i (.ref_clk(ref_clk), .reset_n(reset_n), .link(link), .fracHigh(fracHigh),
    .modHigh(modHigh), .refPulse(refPulse), .pfdPulse(pfdPulse), .pfdInWindow(pfdInWindow),
    .fracValue(fracValue), .modValue(modValue), .clockDividerValue(clockDividerValue),
    .bandSelectDivider(bandSelectDivider), .bandClkPulse(bandClkPulse), .vcoPowerOff(vcoPowerOff),
    .rfMuted(rfMuted), .extInputEnable(extInputEnable), .divFromExternal(divFromExternal),
    .extInputRoute(extInputRoute), .rfOutputEnable(rfOutputEnable), .outputPowerLevel(outputPowerLevel),
    .lockPin(lockPin), .digitalLock(digitalLock));
  synth_cfg_sva synth_cfg_sva_i (.ref_clk(ref_clk), .reset_n(reset_n), .serClk(link.serClk),
    .serData(link.serData), .serLoad(link.serLoad), .fracHigh(fracHigh), .modHigh(modHigh),
    .fracValue(fracValue), .modValue(modValue), .clockDividerValue(clockDividerValue), .rfMuted(rfMuted),
    .digitalLock(digitalLock), .divFromExternal(divFromExternal), .extInputRoute(extInputRoute));
  // Clock, a reference pulse every fourth cycle, and a count of band pulses.
  always #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    pc = pc + 8'h1;
    refPulse = (pc[1:0] == 2'h0);
  end
  always @(posedge ref_clk) if (bandClkPulse === 1'b1) bandCount++;
  // Expected decoded control outputs of a divider word; mute only shows while unlocked.
  function automatic logic [27:0] expDiv(input logic [31:0] v, input logic lk);
    return {v[14:3], v[22:15], v[23], v[24] & !lk, v[25], v[26] & v[27], v[27], v[28], v[30:29]};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One word through the host; the busy wait is bounded so a stuck link ends the run.
  task automatic send(input logic [31:0] v);
    int n;
    @(negedge ref_clk) sendWord = v;
    sendValid = 1'b1;
    @(negedge ref_clk) sendValid = 1'b0;
    for (n = 0; n < 2000 && sendBusy !== 1'b0; n++) @(negedge ref_clk);
    if (n == 2000) begin
      err_total++;
      summarize();
    end
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic pfd(input int n, input logic inw);
    repeat (n) begin
      @(negedge ref_clk) pfdPulse = 1'b1;
      pfdInWindow = inw;
      @(negedge ref_clk) pfdPulse = 1'b0;
    end
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic divWord(input logic mute, input logic [7:0] bs);
    w = $urandom;
    w[3] = 1'b1;
    w[24] = mute;
    w[22:15] = bs;
    send({w[31:3], 3'h4});
    expCtrl = expDiv(w, 1'b0);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    w = $urandom(65720);
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    check("frac", fracValue, 32'h0);
    check("mod", modValue, 32'h2);
    check("ctrl", ctrlSeen, {12'h1, 8'h1, 6'h0, 2'h2});
    check("pin", lockPin, 1'b0);
    for (int i = 0; i < 6; i++) begin
      fracHigh = 12'($urandom);
      modHigh = 12'($urandom);
      w = $urandom;
      if (i == 0) w[22:3] = 20'hfffff;
      send({w[31:23], w[22:3], 3'h3});
      expFrac = {fracHigh, w[22:3]};
      check("frac", fracValue, expFrac);
      divWord(w[24], (i == 0) ? 8'hff : 8'(i + 1));
      if (i == 0) w[14:3] = 12'hfff;
      if (i == 0) send({w[31:3], 3'h4});
      expCtrl = expDiv(w, 1'b0);
      check("ctrl", ctrlSeen, expCtrl);
      w = $urandom;
      w[4] = 1'b1;
      w[24:23] = 2'(i);
      send({w[31:3], 3'h5});
      expMod = {modHigh, w[22:3]};
      check("mod", modValue, expMod);
      check("pin", lockPin, {31'h0, w[24] & w[23]});
    end
    foreach (bad[k]) begin
      w = $urandom;
      send({w[31:3], bad[k]});
      check("frac", fracValue, expFrac);
      check("mod", modValue, expMod);
      check("ctrl", ctrlSeen, expCtrl);
    end
    send({7'h0, 2'b01, expMod[19:0], 3'h5});
    divWord(1'b1, 8'h3);
    bandCount = 0;
    repeat (120) @(negedge ref_clk);
    check("band", 32'(bandCount == 9 || bandCount == 10), 32'h1);
    send({27'h0, 2'b01, 3'h2});
    pfd(1, 1'b0);
    pfd(4, 1'b1);
    check("lock", digitalLock, 1'b0);
    check("mute", rfMuted, 1'b1);
    pfd(1, 1'b1);
    check("lock", digitalLock, 1'b1);
    check("pin", lockPin, 1'b1);
    check("mute", rfMuted, 1'b0);
    pfd(1, 1'b0);
    check("lock", digitalLock, 1'b0);
    send({27'h0, 2'b00, 3'h2});
    pfd(1, 1'b0);
    pfd(39, 1'b1);
    check("lock", digitalLock, 1'b0);
    pfd(1, 1'b1);
    check("lock", digitalLock, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
